// File: shared/cfs_pkg.sv
// shared constants, types and arithmetic for the calibration fault supervisor
`default_nettype none
package cfs_pkg;
   // clock and timing base
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int SHORT_PRESS_MS = 3000;
   localparam int CAL_TIMEOUT_MS = 30000;
   localparam int FLASH_MS = 500;
   localparam logic [15:0] SHORT_PRESS_T = 16'(SHORT_PRESS_MS * 1000 / TICK_US);
   localparam logic [15:0] CAL_TIMEOUT_T = 16'(CAL_TIMEOUT_MS * 1000 / TICK_US);
   localparam logic [15:0] FLASH_T = 16'(FLASH_MS * 1000 / TICK_US);
   // signal limits and reset values
   localparam logic [7:0] WEAK_MIN = 8'h20;
   localparam logic [7:0] STRONG_MAX = 8'he0;
   localparam logic [7:0] REF_RST = 8'h80;
   localparam logic [7:0] NORM_TARGET = 8'h32;
   localparam logic [7:0] NORM_MIN = 8'h30;
   localparam logic [7:0] NORM_MAX = 8'h34;
   localparam logic [6:0] TOL_RST = 7'h23;
   localparam logic [6:0] TOL_MIN = 7'h0a;
   localparam logic [6:0] TOL_MAX = 7'h5a;
   localparam logic [9:0] ERR_ARITH = 10'h065;
   localparam logic [9:0] ERR_TOL = 10'h066;
   // register byte offsets
   localparam logic [7:0] OFS_TOL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_REF = 8'h08;
   localparam logic [7:0] OFS_IRQ_ST = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h10;
   localparam logic [7:0] OFS_FATAL = 8'h14;
   // interrupt status bit positions
   localparam int IRQ_OK = 0;
   localparam int IRQ_FAIL = 2;
   localparam int IRQ_TMO = 4;
   localparam int IRQ_PRB = 6;
   localparam int IRQ_FATAL = 8;
   localparam int IRQ_W = 9;
   typedef enum logic [1:0] {
      CFS_RUN = 2'b00, CFS_CAL = 2'b01, CFS_WEAK = 2'b10, CFS_STRONG = 2'b11
   } cfs_cal_e;
   typedef enum logic [2:0] {
      SYM_NUM = 3'b000, SYM_CAL = 3'b001, SYM_WEAK = 3'b010, SYM_STRONG = 3'b011,
      SYM_PROBE = 3'b100, SYM_FATAL = 3'b101
   } cfs_sym_e;
   // level scaled so that the reference reads as the target value
   function automatic logic [7:0] norm(input logic [7:0] lvl, input logic [7:0] refv);
      logic [15:0] p;
      p = 16'(lvl) * 16'(NORM_TARGET);
      if (refv == 8'h00) return 8'hff;
      p = p / 16'(refv);
      return (p > 16'h00ff) ? 8'hff : p[7:0];
   endfunction
   // two-blank threshold: reference minus tolerance share of it
   function automatic logic [7:0] thresh(input logic [7:0] refv, input logic [6:0] tol);
      logic [15:0] p;
      p = (16'(refv) * 16'(tol)) / 16'h0064;
      return refv - p[7:0];
   endfunction
endpackage
`default_nettype wire

// File: logic/cfs_press.sv
// press length timer: short press requests calibration, long press parameter view
`timescale 1ns/1ps
`default_nettype none
module cfs_press (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   input wire logic held,
   output logic short_pulse,
   output logic long_pulse
);
   logic [15:0] cnt_q, cnt_d;
   logic held_q;

   // count held time in ticks, saturating at the long press limit
   always_comb begin
      cnt_d = cnt_q;
      if (!held) begin
         cnt_d = 16'h0000;
      end else if (tick && cnt_q != cfs_pkg::SHORT_PRESS_T) begin
         cnt_d = cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 16'h0000;
         held_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         held_q <= held;
      end
   end

   // release before the limit calibrates; reaching it while held does not
   assign short_pulse = held_q && !held && cnt_q < cfs_pkg::SHORT_PRESS_T;
   assign long_pulse = held && tick && cnt_q == cfs_pkg::SHORT_PRESS_T - 16'h0001;

   long_no_cal_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cnt_q == cfs_pkg::SHORT_PRESS_T) |-> !short_pulse)
      else $error("long press started calibration");
endmodule // cfs_press
`default_nettype wire

// File: logic/cfs_cal.sv
// per-channel calibration sequencer with failure timeout and reference restore
`timescale 1ns/1ps
`default_nettype none
module cfs_cal (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   input wire logic req,
   input wire logic [7:0] level,
   output logic [1:0] state,
   output logic [7:0] ref_level,
   output logic ev_ok,
   output logic ev_fail,
   output logic ev_timeout
);
   cfs_pkg::cfs_cal_e st_q, st_d;
   logic [7:0] ref_q, ref_d, prev_q, prev_d;
   logic [15:0] wait_q, wait_d;

   // a new request always restarts; the verdict is taken on the next tick
   always_comb begin
      st_d = st_q;
      ref_d = ref_q;
      prev_d = prev_q;
      wait_d = wait_q;
      ev_ok = 1'b0;
      ev_fail = 1'b0;
      ev_timeout = 1'b0;
      if (req) begin
         if (st_q == cfs_pkg::CFS_RUN) prev_d = ref_q;
         st_d = cfs_pkg::CFS_CAL;
         wait_d = 16'h0000;
      end else begin
         case (st_q)
            cfs_pkg::CFS_CAL: begin
               if (tick && level < cfs_pkg::WEAK_MIN) begin
                  st_d = cfs_pkg::CFS_WEAK;
                  ev_fail = 1'b1;
               end else if (tick && level > cfs_pkg::STRONG_MAX) begin
                  st_d = cfs_pkg::CFS_STRONG;
                  ev_fail = 1'b1;
               end else if (tick) begin
                  ref_d = level;
                  st_d = cfs_pkg::CFS_RUN;
                  ev_ok = 1'b1;
               end
            end
            cfs_pkg::CFS_WEAK, cfs_pkg::CFS_STRONG: begin
               if (tick && wait_q == cfs_pkg::CAL_TIMEOUT_T - 16'h0001) begin
                  st_d = cfs_pkg::CFS_RUN;
                  ref_d = prev_q;
                  ev_timeout = 1'b1;
               end else if (tick) begin
                  wait_d = wait_q + 16'h0001;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= cfs_pkg::CFS_RUN;
         ref_q <= cfs_pkg::REF_RST;
         prev_q <= cfs_pkg::REF_RST;
         wait_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         ref_q <= ref_d;
         prev_q <= prev_d;
         wait_q <= wait_d;
      end
   end

   assign state = st_q;
   assign ref_level = ref_q;

   success_ref_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ev_ok |=> st_q == cfs_pkg::CFS_RUN && ref_q == $past(level))
      else $error("success did not store level as reference");
   restore_ref_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ev_timeout |=> st_q == cfs_pkg::CFS_RUN && ref_q == $past(prev_q))
      else $error("timeout did not restore previous reference");
   fail_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wait_q < cfs_pkg::CAL_TIMEOUT_T)
      else $error("failure wait overran timeout");
   fail_keeps_ref_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ev_fail |=> ref_q == $past(ref_q) && st_q != cfs_pkg::CFS_RUN)
      else $error("failed calibration changed reference");
endmodule // cfs_cal
`default_nettype wire

// File: logic/cfs_top.sv
// calibration and fault supervisor: ahb-lite registers, pins, displays
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - calibrating channel alternates indicators, shows CAL
// - success stops flashing quickly, shows 48..52
// - weak signal alternates CAL with weak tag
// - strong signal alternates CAL with strong tag
// - failure idle 30 s restores previous reference
// - remote input acts exactly like pushbutton
// - probe faults shown as tag with 1/2/3
// - full diagnostics at power-up, light while running
// - fatal fault shows tag with numeric code
// - channel fault turns its fault output off
// - fault outputs on when healthy, channels independent
// - polarity switch picks sourcing or sinking drivers
// - tolerance defaults to 35 percent
// - short press calibrates, long press views parameters
// - swap input inverts selected material
module cfs_top #(
   parameter int TICK_CYCLES = cfs_pkg::TICK_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [1:0] cal_button,
   input wire logic [1:0] cal_remote,
   input wire logic [1:0] tx_probe_fault,
   input wire logic [1:0] rx_probe_fault,
   input wire logic [1:0] material_swap,
   input wire logic steel_material_select,
   input wire logic driver_polarity_select,
   input wire logic adjustable_threshold_select,
   input wire logic [7:0] rx_level_0,
   input wire logic [7:0] rx_level_1,
   output logic [1:0] one_blank_output,
   output logic [1:0] two_blank_output,
   output logic [1:0] fault_output,
   output logic [1:0] steel_sense,
   output logic [1:0] param_view,
   output logic [5:0] disp_sym,
   output logic [19:0] disp_num,
   output logic irq
);
   logic [12:0] raw, s1_q, s2_q;
   logic [1:0] boot_q;
   logic steel_q, sinking_q, adj_q;
   logic [16:0] div_q;
   logic tick;
   logic [15:0] fl_cnt_q;
   logic flash_q;
   logic [7:0] lvl [2];
   logic [1:0] cal_st [2];
   logic [7:0] refl [2];
   logic [1:0] ev_ok, ev_fail, ev_tmo, cal_req, prb;

   // pins and switches other than rx_level_0 and rx_level_1 pass two flops before any logic reads them
   assign raw = {adjustable_threshold_select, driver_polarity_select, steel_material_select,
                 material_swap, rx_probe_fault, tx_probe_fault, cal_remote, cal_button};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= 13'h0000;
         s2_q <= 13'h0000;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   // switches are sampled only in the first three cycles after reset, so later flips need a restart
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         boot_q <= 2'h0;
         steel_q <= 1'b0;
         sinking_q <= 1'b0;
         adj_q <= 1'b0;
      end else if (boot_q != 2'h3) begin
         boot_q <= boot_q + 2'h1;
         steel_q <= s2_q[10];
         sinking_q <= s2_q[11];
         adj_q <= s2_q[12];
      end
   end

   // millisecond tick and half-second flash phase
   assign tick = div_q == 17'(TICK_CYCLES - 1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 17'h00000;
         fl_cnt_q <= 16'h0000;
         flash_q <= 1'b0;
      end else begin
         div_q <= tick ? 17'h00000 : div_q + 17'h00001;
         if (tick && fl_cnt_q == cfs_pkg::FLASH_T - 16'h0001) begin
            fl_cnt_q <= 16'h0000;
            flash_q <= !flash_q;
         end else if (tick) begin
            fl_cnt_q <= fl_cnt_q + 16'h0001;
         end
      end
   end

   assign lvl[0] = rx_level_0;
   assign lvl[1] = rx_level_1;

   // per channel: one press timer fed by both the button and the remote input
   for (genvar c = 0; c < 2; c++) begin : g_ch
      cfs_press u_press (
         .hclk(hclk),
         .hresetn(hresetn),
         .tick(tick),
         .held(s2_q[c] | s2_q[2 + c]),
         .short_pulse(cal_req[c]),
         .long_pulse(param_view[c])
      );
      cfs_cal u_cal (
         .hclk(hclk),
         .hresetn(hresetn),
         .tick(tick),
         .req(cal_req[c]),
         .level(lvl[c]),
         .state(cal_st[c]),
         .ref_level(refl[c]),
         .ev_ok(ev_ok[c]),
         .ev_fail(ev_fail[c]),
         .ev_timeout(ev_tmo[c])
      );
      assign prb[c] = s2_q[4 + c] | s2_q[6 + c];
      assign steel_sense[c] = steel_q ^ s2_q[8 + c];
   end

   // self test: every divisor from 1 to 255 once after reset, then one point per tick
   logic diag_full_q, diag_full_d, fatal_q, fatal_d;
   logic [7:0] didx_q, didx_d;
   logic [9:0] fcode_q, fcode_d;
   logic [6:0] tol_q;
   always_comb begin
      diag_full_d = diag_full_q;
      didx_d = didx_q;
      fatal_d = fatal_q;
      fcode_d = fcode_q;
      if (diag_full_q || tick) begin
         didx_d = (didx_q == 8'hff) ? 8'h01 : didx_q + 8'h01;
         if (didx_q == 8'hff) diag_full_d = 1'b0;
      end
      if (!fatal_q && cfs_pkg::norm(didx_q, didx_q) != cfs_pkg::NORM_TARGET) begin
         fatal_d = 1'b1;
         fcode_d = cfs_pkg::ERR_ARITH;
      end else if (!fatal_q && (tol_q < cfs_pkg::TOL_MIN || tol_q > cfs_pkg::TOL_MAX)) begin
         fatal_d = 1'b1;
         fcode_d = cfs_pkg::ERR_TOL;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         diag_full_q <= 1'b1;
         didx_q <= 8'h01;
         fatal_q <= 1'b0;
         fcode_q <= 10'h000;
      end else begin
         diag_full_q <= diag_full_d;
         didx_q <= didx_d;
         fatal_q <= fatal_d;
         fcode_q <= fcode_d;
      end
   end

   // displays and outputs; on the displays fatal beats probe fault beats calibration
   logic [2:0] sym_d [2], sym_q [2];
   logic [9:0] num_d [2], num_q [2];
   logic [1:0] one_d, two_d, fok_d, one_q, two_q, fok_q;
   logic [6:0] tol_eff;
   assign tol_eff = adj_q ? tol_q : cfs_pkg::TOL_RST;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         sym_d[c] = cfs_pkg::SYM_NUM;
         num_d[c] = {2'h0, cfs_pkg::norm(lvl[c], refl[c])};
         one_d[c] = flash_q;
         two_d[c] = !flash_q;
         fok_d[c] = !(prb[c] | fatal_q);
         if (fatal_q) begin
            sym_d[c] = flash_q ? cfs_pkg::SYM_FATAL : cfs_pkg::SYM_NUM;
            num_d[c] = fcode_q;
         end else if (prb[c]) begin
            sym_d[c] = flash_q ? cfs_pkg::SYM_PROBE : cfs_pkg::SYM_NUM;
            num_d[c] = {8'h00, s2_q[6 + c], s2_q[4 + c]};
         end else if (cal_st[c] == cfs_pkg::CFS_CAL) begin
            sym_d[c] = cfs_pkg::SYM_CAL;
         end else if (cal_st[c] == cfs_pkg::CFS_WEAK) begin
            sym_d[c] = flash_q ? cfs_pkg::SYM_CAL : cfs_pkg::SYM_WEAK;
         end else if (cal_st[c] == cfs_pkg::CFS_STRONG) begin
            sym_d[c] = flash_q ? cfs_pkg::SYM_CAL : cfs_pkg::SYM_STRONG;
         end
         if (cal_st[c] == cfs_pkg::CFS_RUN) begin
            one_d[c] = lvl[c] <= cfs_pkg::STRONG_MAX;
            two_d[c] = lvl[c] <= cfs_pkg::STRONG_MAX && lvl[c] < cfs_pkg::thresh(refl[c], tol_eff);
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int c = 0; c < 2; c++) begin
            sym_q[c] <= cfs_pkg::SYM_NUM;
            num_q[c] <= 10'h000;
         end
         one_q <= 2'h0;
         two_q <= 2'h0;
         fok_q <= 2'h0;
      end else begin
         sym_q <= sym_d;
         num_q <= num_d;
         one_q <= one_d;
         two_q <= two_d;
         fok_q <= fok_d;
      end
   end

   // sinking drivers pull low when on, so the pin level inverts
   assign one_blank_output = one_q ^ {2{sinking_q}};
   assign two_blank_output = two_q ^ {2{sinking_q}};
   assign fault_output = fok_q ^ {2{sinking_q}};
   assign disp_sym = {sym_q[1], sym_q[0]};
   assign disp_num = {num_q[1], num_q[0]};

   // bus slave: zero wait states, read data registered in the address phase
   logic wr_q, wr_d, irq_q, irq_d;
   logic [7:0] wa_q, wa_d;
   logic [31:0] rd_q, rd_d;
   logic [6:0] tol_d;
   logic [8:0] ist_q, ist_d, imsk_q, imsk_d, ev;
   logic [1:0] prb_q;
   logic [13:0] stat;
   logic ap;
   assign ap = hsel && htrans[1] && hready;
   assign ev = {fatal_d & !fatal_q, prb & ~prb_q, ev_tmo, ev_fail, ev_ok};
   assign stat = {diag_full_q, adj_q, sinking_q, steel_sense, fatal_q, s2_q[7:4],
                  cal_st[1], cal_st[0]};
   always_comb begin
      wr_d = ap && hwrite && hsize == 3'h2;
      wa_d = haddr[7:0];
      rd_d = rd_q;
      tol_d = tol_q;
      imsk_d = imsk_q;
      ist_d = ist_q;
      if (ap && !hwrite) begin
         if (haddr[7:0] == cfs_pkg::OFS_TOL) rd_d = {25'h0, tol_q};
         else if (haddr[7:0] == cfs_pkg::OFS_STAT) rd_d = {18'h0, stat};
         else if (haddr[7:0] == cfs_pkg::OFS_REF) rd_d = {16'h0, refl[1], refl[0]};
         else if (haddr[7:0] == cfs_pkg::OFS_IRQ_ST) rd_d = {23'h0, ist_q};
         else if (haddr[7:0] == cfs_pkg::OFS_IRQ_MSK) rd_d = {23'h0, imsk_q};
         else if (haddr[7:0] == cfs_pkg::OFS_FATAL) rd_d = {22'h0, fcode_q};
         else rd_d = 32'h0000_0000;
      end
      if (wr_q) begin
         if (wa_q == cfs_pkg::OFS_TOL) begin
            if (hwdata[6:0] >= cfs_pkg::TOL_MIN && hwdata[6:0] <= cfs_pkg::TOL_MAX)
               tol_d = hwdata[6:0];
         end else if (wa_q == cfs_pkg::OFS_IRQ_ST) begin
            ist_d = ist_q & ~hwdata[8:0];
         end else if (wa_q == cfs_pkg::OFS_IRQ_MSK) begin
            imsk_d = hwdata[8:0];
         end
      end
      ist_d = ist_d | ev; // a new event beats a same-cycle clear
      irq_d = |(ist_d & imsk_d);
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         rd_q <= 32'h0000_0000;
         tol_q <= cfs_pkg::TOL_RST;
         ist_q <= 9'h000;
         imsk_q <= 9'h000;
         irq_q <= 1'b0;
         prb_q <= 2'h0;
      end else begin
         wr_q <= wr_d;
         wa_q <= wa_d;
         rd_q <= rd_d;
         tol_q <= tol_d;
         ist_q <= ist_d;
         imsk_q <= imsk_d;
         irq_q <= irq_d;
         prb_q <= prb;
      end
   end
   assign hrdata = rd_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = irq_q;

   fault_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      prb[0] |=> !fok_q[0])
      else $error("channel 0 fault output stayed on");
   fault_indep_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!prb[1] && !fatal_q && prb[0]) |=> fok_q[1] && !fok_q[0])
      else $error("fault crossed channels");
   tol_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tol_q >= cfs_pkg::TOL_MIN && tol_q <= cfs_pkg::TOL_MAX)
      else $error("tolerance outside range");
   cal_flash_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cal_st[0] == cfs_pkg::CFS_CAL) |=> one_q[0] != two_q[0])
      else $error("indicators not alternating in calibration");
   cal_text_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cal_st[0] == cfs_pkg::CFS_CAL && !fatal_q && !prb[0]) |=> sym_q[0] == cfs_pkg::SYM_CAL)
      else $error("calibrating text missing");
   ok_value_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ev_ok[0] && !fatal_q && !prb[0]) ##1 $stable(lvl[0]) |=>
      num_q[0] >= {2'h0, cfs_pkg::NORM_MIN} && num_q[0] <= {2'h0, cfs_pkg::NORM_MAX})
      else $error("post-calibration value outside 48..52");
   weak_text_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cal_st[0] == cfs_pkg::CFS_WEAK && !fatal_q && !prb[0] && !flash_q) |=>
      sym_q[0] == cfs_pkg::SYM_WEAK)
      else $error("weak tag missing");
   diag_sweep_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (diag_full_q && didx_q != 8'hff) |=> diag_full_q && didx_q == $past(didx_q) + 8'h01)
      else $error("power-up sweep broken");
   fatal_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fatal_q |=> fatal_q && num_q[0] == fcode_q)
      else $error("fatal code not shown");
   polarity_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fault_output[1] == (fok_q[1] ^ sinking_q))
      else $error("driver polarity wrong");
endmodule // cfs_top
`default_nettype wire

// File: sim/cfs_partner.sv
// controller and probe pair model at the far side of the supervisor
`timescale 1ns/1ps
`default_nettype none
module cfs_partner (
   input wire logic hclk,
   input wire logic sinking,
   input wire logic [1:0] fault_output,
   input wire logic [1:0] go,
   input wire logic [7:0] lvl0,
   input wire logic [7:0] lvl1,
   input wire logic [1:0] txf,
   input wire logic [1:0] rxf,
   output logic [1:0] cal_remote,
   output logic [7:0] rx_level_0,
   output logic [7:0] rx_level_1,
   output logic [1:0] tx_probe_fault,
   output logic [1:0] rx_probe_fault
);
   logic [3:0] hold_q [2];
   initial begin
      cal_remote = 2'b00;
      rx_level_0 = 8'h80;
      rx_level_1 = 8'h80;
      tx_probe_fault = 2'b00;
      rx_probe_fault = 2'b00;
      hold_q[0] = 4'h0;
      hold_q[1] = 4'h0;
   end
   // a request is refused on a channel that shows a fault; short hold keeps it clear of the long press
   always @(posedge hclk) begin
      rx_level_0 <= lvl0;
      rx_level_1 <= lvl1;
      tx_probe_fault <= txf;
      rx_probe_fault <= rxf;
      for (int c = 0; c < 2; c++) begin
         if (go[c] && (fault_output[c] ^ sinking) && hold_q[c] == 4'h0) hold_q[c] <= 4'h8;
         else if (hold_q[c] != 4'h0) hold_q[c] <= hold_q[c] - 4'h1;
         cal_remote[c] <= (hold_q[c] != 4'h0);
      end
   end
endmodule // cfs_partner
`default_nettype wire

// File: sim/cfs_top_tb.sv
// self-checking bench for the calibration fault supervisor
`timescale 1ns/1ps
`default_nettype none
module cfs_top_tb;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dp = 0, irq, hresp, hreadyout, sw = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'hcf45;
   logic [1:0] htrans = 0, btn = 0, go = 0, txf = 0, rxf = 0, swap = 0, rem, tpf, rpf;
   logic [1:0] one_b, two_b, fout, steel, pv;
   logic [2:0] hsize = 3'b010;
   logic [7:0] l0 = 8'h80, l1 = 8'h80, r0, r1, lv;
   logic [5:0] sym;
   logic [19:0] num;
   logic [31:0] q[$];
   int bad_count = 0, samples_checked = 0, pvn = 0;
   cfs_top #(.TICK_CYCLES(2)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cal_button(btn), .cal_remote(rem),
      .tx_probe_fault(tpf), .rx_probe_fault(rpf), .material_swap(swap), .steel_material_select(sw),
      .driver_polarity_select(sw), .adjustable_threshold_select(sw), .rx_level_0(r0), .rx_level_1(r1),
      .one_blank_output(one_b), .two_blank_output(two_b), .fault_output(fout), .steel_sense(steel),
      .param_view(pv), .disp_sym(sym), .disp_num(num), .irq(irq));
   cfs_partner i_far (.hclk(hclk), .sinking(sw), .fault_output(fout), .go(go), .lvl0(l0), .lvl1(l1),
      .txf(txf), .rxf(rxf), .cal_remote(rem), .rx_level_0(r0), .rx_level_1(r1), .tx_probe_fault(tpf),
      .rx_probe_fault(rpf));
   initial forever #5 hclk = ~hclk;
   // random source for stimulus values
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one single word transfer; for a read d is the expected word, compared by the monitor
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= w ? d : 32'h0;
      if (!w) q.push_back(d);
      dp <= !w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      dp <= 1'b0;
   endtask
   // read data is taken at the edge that closes the data phase
   always @(posedge hclk) begin
      if (dp && hreadyout === 1'b1) begin
         chk(hrdata, q.pop_front());
         chk({31'h0, hresp}, 32'h0);
      end
   end
   always @(posedge hclk) if (pv[0] === 1'b1) pvn++;
   // sample a display over several flash phases: only the two symbols, both seen
   task automatic watch(input int c, input logic [2:0] a, input logic [2:0] b, input logic [9:0] n);
      int sa, sb;
      sa = 0;
      sb = 0;
      repeat (2200) begin
         @(negedge hclk);
         if (sym[c*3+:3] === a) sa++;
         if (sym[c*3+:3] === b && (n === 10'h3ff || num[c*10+:10] === n)) sb++;
      end
      chk(32'(sa > 0 && sb > 0 && sa + sb == 2200), 32'h1);
   endtask
   task automatic req(input logic [1:0] c);
      @(posedge hclk) go <= c;
      @(posedge hclk) go <= 2'b00;
      repeat (40) @(posedge hclk);
   endtask
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge hclk);
      bad_count++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      bus(0, 8'h00, 32'h23);
      bus(0, 8'h08, 32'h8080);
      bus(1, 8'h00, 32'h5b);
      bus(0, 8'h00, 32'h23);
      bus(1, 8'h00, 32'h0a);
      bus(0, 8'h00, 32'h0a);
      bus(0, 8'h18, 32'h0);
      repeat (300) @(posedge hclk);
      l0 <= 8'h10;
      @(posedge hclk) btn <= 2'b01;
      repeat (8) @(posedge hclk);
      btn <= 2'b00;
      repeat (40) @(posedge hclk);
      bus(0, 8'h04, 32'h002);
      watch(0, cfs_pkg::SYM_CAL, cfs_pkg::SYM_WEAK, 10'h3ff);
      l1 <= 8'h60;
      req(2'b10);
      bus(0, 8'h08, 32'h6080);
      l1 <= 8'hf0;
      req(2'b10);
      bus(0, 8'h04, 32'h00e);
      watch(1, cfs_pkg::SYM_CAL, cfs_pkg::SYM_STRONG, 10'h3ff);
      seed = lfsr(seed);
      lv = 8'h40 + {3'h0, seed[4:0]};
      l0 <= lv;
      req(2'b01);
      bus(0, 8'h04, 32'h00c);
      bus(0, 8'h08, {16'h0, 8'h60, lv});
      chk({num[9:0], sym[2:0]}, {10'h032, 3'h0});
      chk({one_b[0], two_b[0]}, 2'b10);
      l0 <= lv >> 1;
      repeat (6) @(posedge hclk);
      chk({one_b[0], two_b[0]}, 2'b11);
      l0 <= lv;
      repeat (6) @(posedge hclk);
      bus(0, 8'h0c, 32'h00f);
      bus(1, 8'h10, 32'h001);
      repeat (3) @(posedge hclk);
      chk(irq, 1);
      bus(1, 8'h0c, 32'h1ff);
      repeat (3) @(posedge hclk);
      chk(irq, 0);
      bus(1, 8'h10, 32'h0);
      @(posedge hclk) btn <= 2'b01;
      repeat (6100) @(posedge hclk);
      btn <= 2'b00;
      repeat (40) @(posedge hclk);
      chk(pvn, 1);
      bus(0, 8'h04, 32'h00c);
      repeat (62000) @(posedge hclk);
      bus(0, 8'h04, 32'h0);
      bus(0, 8'h08, {16'h0, 8'h60, lv});
      bus(0, 8'h0c, 32'h020);
      for (int k = 1; k < 4; k++) begin
         txf <= {1'b0, k[0]};
         rxf <= {1'b0, k[1]};
         repeat (10) @(posedge hclk);
         chk(fout, 2'b10);
         watch(0, cfs_pkg::SYM_PROBE, cfs_pkg::SYM_NUM, 10'(k));
         txf <= 2'b00;
         rxf <= 2'b00;
         repeat (10) @(posedge hclk);
         chk(fout, 2'b11);
      end
      bus(0, 8'h0c, 32'h060);
      @(posedge hclk) hresetn <= 1'b0;
      sw <= 1'b1;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (10) @(posedge hclk);
      bus(0, 8'h04, 32'h3e00);
      chk({fout, steel}, 4'b0011);
      swap <= 2'b01;
      repeat (10) @(posedge hclk);
      chk(steel, 2'b10);
      close_out();
   end
endmodule // cfs_top_tb
`default_nettype wire
